//--- pcer_en_bank.sv
/*
  One set/clear enable bank: a single stored vector reached by two addresses.
  Assumes set and clear writes never arrive in the same cycle.
*/
`timescale 1ns/1ps
`default_nettype none
module pcer_en_bank #(
  parameter logic [31:0] MASK = 32'hffff_ffff
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic set_wr,
  input wire logic clr_wr,
  input wire logic [pcer_pkg::PCER_DW-1:0] wdata,
  output logic [pcer_pkg::PCER_DW-1:0] en_q
);
  import pcer_pkg::*;

  // reserved bits never store, so they read as zero
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      en_q <= PCER_EN_RST;
    end else if (set_wr) begin
      en_q <= en_q | (wdata & MASK);
    end else if (clr_wr) begin
      en_q <= en_q & ~(wdata & MASK);
    end
  end
endmodule
`default_nettype wire

//--- pcer_flag_bank.sv
/*
  Sticky overflow flags, cleared by writing one.
  Assumes overflow events are one-cycle pulses from logic on the same clock.
*/
`timescale 1ns/1ps
`default_nettype none
module pcer_flag_bank #(
  parameter logic [31:0] MASK = 32'hffff_ffff
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [pcer_pkg::PCER_DW-1:0] set_evt,
  input wire logic clr_wr,
  input wire logic [pcer_pkg::PCER_DW-1:0] wdata,
  output logic [pcer_pkg::PCER_DW-1:0] flag_q
);
  import pcer_pkg::*;

  logic [PCER_DW-1:0] clr_vec;

  assign clr_vec = clr_wr ? (wdata & MASK) : '0;

  // a new overflow beats a clear in the same cycle, so none is lost
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      flag_q <= PCER_FLAG_RST;
    end else begin
      flag_q <= ((flag_q & ~clr_vec) | set_evt) & MASK;
    end
  end
endmodule
`default_nettype wire

//--- pcer_ovf_model.sv
/*
  Far-side model: the overflow sources feeding the enable bank.
  Assumes the bench holds a request for one clk cycle; each request becomes
  a one-cycle overflow pulse on the same clock.
*/
`timescale 1ns/1ps
`default_nettype none
module pcer_ovf_model #(
  parameter int unsigned NUM_CNT = 4
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [31:0] fire,
  output logic [NUM_CNT-1:0] evt_ovf,
  output logic cyc_ovf
);
  // registered so pulses never change on the edge that samples them
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      evt_ovf <= '0;
      cyc_ovf <= 1'b0;
    end else begin
      evt_ovf <= fire[NUM_CNT-1:0];
      cyc_ovf <= fire[31];
    end
  end
endmodule
`default_nettype wire

//--- pcer_pkg.sv
/*
  Constants shared by the performance monitor enable and interrupt bank.
  Assumes a 32-bit register port; the cycle counter sits on bit 31.
*/
`default_nettype none
package pcer_pkg;
  localparam int unsigned PCER_DW = 32;
  localparam int unsigned PCER_AW = 8;
  localparam logic [7:0] PCER_OFF_IEN_SET = 8'h00;
  localparam logic [7:0] PCER_OFF_IEN_CLR = 8'h04;
  localparam logic [7:0] PCER_OFF_CEN_SET = 8'h08;
  localparam logic [7:0] PCER_OFF_CEN_CLR = 8'h0c;
  localparam logic [7:0] PCER_OFF_CTRL = 8'h10;
  localparam logic [7:0] PCER_OFF_FLAG = 8'h14;
  localparam int unsigned PCER_CYC_BIT = 31;
  localparam int unsigned PCER_GEN_BIT = 0;
  localparam int unsigned PCER_NCNT_LSB = 11;
  localparam int unsigned PCER_NCNT_W = 5;
  localparam logic [31:0] PCER_EN_RST = 32'h0000_0000;
  localparam logic [31:0] PCER_FLAG_RST = 32'h0000_0000;
  localparam logic PCER_GEN_RST = 1'b0;

  // implemented bits: counters below n plus the cycle counter
  function automatic logic [31:0] pcer_impl_mask(input int unsigned n);
    logic [31:0] m;
    m = 32'h0000_0000;
    for (int i = 0; i < 31; i++) begin
      if (i < n) begin
        m[i] = 1'b1;
      end
    end
    m[PCER_CYC_BIT] = 1'b1;
    return m;
  endfunction
endpackage
`default_nettype wire

//--- pcer_top.sv
/*
  Performance monitor enable bank: interrupt and count enables with set and
  clear views, global enable, overflow flags and the exported interrupt.
  Assumes a single-cycle register port from privileged core logic on clk;
  overflow pulses and the user-mode level come from the same clock domain.
*/
`timescale 1ns/1ps
`default_nettype none
module pcer_top #(
  parameter int unsigned NUM_CNT = 4
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic [pcer_pkg::PCER_AW-1:0] reg_addr,
  input wire logic [pcer_pkg::PCER_DW-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [pcer_pkg::PCER_DW-1:0] reg_rdata,
  input wire logic user_mode,
  output logic access_undef,
  input wire logic [NUM_CNT-1:0] evt_ovf,
  input wire logic cyc_ovf,
  output logic [NUM_CNT-1:0] cnt_run,
  output logic cyc_run,
  output logic ovf_irq
);
  import pcer_pkg::*;

  localparam logic [31:0] IMPL_MASK = pcer_impl_mask(NUM_CNT);
  localparam logic [PCER_NCNT_W-1:0] NCNT_VAL = PCER_NCNT_W'(NUM_CNT);

  function automatic logic hit(input logic [PCER_AW-1:0] a, input logic [PCER_AW-1:0] off);
    return a == off;
  endfunction

  function automatic logic mapped(input logic [PCER_AW-1:0] a);
    return hit(a, PCER_OFF_IEN_SET) || hit(a, PCER_OFF_IEN_CLR) ||
           hit(a, PCER_OFF_CEN_SET) || hit(a, PCER_OFF_CEN_CLR) ||
           hit(a, PCER_OFF_CTRL) || hit(a, PCER_OFF_FLAG);
  endfunction

  logic [1:0] rst_sync_q;
  logic rst_n;
  logic wr_ok;
  logic rd_ok;
  logic [PCER_DW-1:0] ien_q;
  logic [PCER_DW-1:0] cen_q;
  logic [PCER_DW-1:0] flag_q;
  logic [PCER_DW-1:0] ovf_vec;
  logic [PCER_DW-1:0] rdata_d;
  logic [PCER_DW-1:0] rdata_q;
  logic gen_en_q;
  logic undef_q;
  logic irq_d;
  logic irq_q;
  logic [NUM_CNT-1:0] cnt_run_q;
  logic cyc_run_q;

  // reset released through two flops so release is clean on clk
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rst_sync_q <= 2'h0;
    end else begin
      rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
  end

  assign rst_n = rst_sync_q[1];

  // user-mode accesses are dropped whole: no store, no read data
  assign wr_ok = reg_wr && !user_mode;
  assign rd_ok = reg_rd && !user_mode;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      undef_q <= 1'b0;
    end else begin
      undef_q <= (reg_wr || reg_rd) && user_mode && mapped(reg_addr);
    end
  end

  // counter i on bit i, cycle counter on the top bit
  generate
    for (genvar i = 0; i < 31; i++) begin : g_ovf
      if (i < NUM_CNT) begin : g_impl
        assign ovf_vec[i] = evt_ovf[i];
      end else begin : g_rsv
        assign ovf_vec[i] = 1'b0;
      end
    end
  endgenerate

  assign ovf_vec[PCER_CYC_BIT] = cyc_ovf;

  pcer_en_bank #(
    .MASK(IMPL_MASK)
  ) u_ien (
    .clk(clk),
    .rst_n(rst_n),
    .set_wr(wr_ok && hit(reg_addr, PCER_OFF_IEN_SET)),
    .clr_wr(wr_ok && hit(reg_addr, PCER_OFF_IEN_CLR)),
    .wdata(reg_wdata),
    .en_q(ien_q)
  );

  pcer_en_bank #(
    .MASK(IMPL_MASK)
  ) u_cen (
    .clk(clk),
    .rst_n(rst_n),
    .set_wr(wr_ok && hit(reg_addr, PCER_OFF_CEN_SET)),
    .clr_wr(wr_ok && hit(reg_addr, PCER_OFF_CEN_CLR)),
    .wdata(reg_wdata),
    .en_q(cen_q)
  );

  pcer_flag_bank #(
    .MASK(IMPL_MASK)
  ) u_flag (
    .clk(clk),
    .rst_n(rst_n),
    .set_evt(ovf_vec),
    .clr_wr(wr_ok && hit(reg_addr, PCER_OFF_FLAG)),
    .wdata(reg_wdata),
    .flag_q(flag_q)
  );

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      gen_en_q <= PCER_GEN_RST;
    end else if (wr_ok && hit(reg_addr, PCER_OFF_CTRL)) begin
      gen_en_q <= reg_wdata[PCER_GEN_BIT];
    end
  end

  // count enables are only masked here, never cleared, by the global bit
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_run_q <= '0;
      cyc_run_q <= 1'b0;
    end else begin
      cnt_run_q <= cen_q[NUM_CNT-1:0] & {NUM_CNT{gen_en_q}};
      cyc_run_q <= cen_q[PCER_CYC_BIT] && gen_en_q;
    end
  end

  // level interrupt: falls once the flag, its enable or the global enable goes
  assign irq_d = gen_en_q && (|(flag_q & ien_q));

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= irq_d;
    end
  end

  always_comb begin
    rdata_d = '0;
    unique case (1'b1)
      hit(reg_addr, PCER_OFF_IEN_SET): rdata_d = ien_q;
      hit(reg_addr, PCER_OFF_IEN_CLR): rdata_d = ien_q;
      hit(reg_addr, PCER_OFF_CEN_SET): rdata_d = cen_q;
      hit(reg_addr, PCER_OFF_CEN_CLR): rdata_d = cen_q;
      hit(reg_addr, PCER_OFF_CTRL): begin
        rdata_d[PCER_GEN_BIT] = gen_en_q;
        rdata_d[PCER_NCNT_LSB +: PCER_NCNT_W] = NCNT_VAL;
      end
      hit(reg_addr, PCER_OFF_FLAG): rdata_d = flag_q;
      default: rdata_d = '0;
    endcase
  end

  // read data valid only in the cycle after the strobe, zero otherwise
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata_q <= '0;
    end else begin
      rdata_q <= rd_ok ? rdata_d : '0;
    end
  end

  assign reg_rdata = rdata_q;
  assign access_undef = undef_q;
  assign cnt_run = cnt_run_q;
  assign cyc_run = cyc_run_q;
  assign ovf_irq = irq_q;

  // helpers read only by the checks below
  logic [PCER_DW-1:0] wmask_q;
  logic [PCER_DW-1:0] evt_q;
  logic [PCER_DW-1:0] ien_prev_q;
  logic [PCER_DW-1:0] cen_prev_q;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wmask_q <= '0;
      evt_q <= '0;
      ien_prev_q <= '0;
      cen_prev_q <= '0;
    end else begin
      wmask_q <= reg_wdata & IMPL_MASK;
      evt_q <= ovf_vec;
      ien_prev_q <= ien_q;
      cen_prev_q <= cen_q;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  irq_set_write_a: assert property (
    wr_ok && hit(reg_addr, PCER_OFF_IEN_SET) |=> (ien_q & wmask_q) == wmask_q
  ) else $error("irq enable set write did not enable");

  irq_clr_write_a: assert property (
    wr_ok && hit(reg_addr, PCER_OFF_IEN_CLR) |=> (ien_q & wmask_q) == '0
  ) else $error("irq enable clear write did not disable");

  cnt_set_write_a: assert property (
    wr_ok && hit(reg_addr, PCER_OFF_CEN_SET) |=> ((cen_q & wmask_q) == wmask_q)
      && ((cen_q & ~wmask_q) == (cen_prev_q & ~wmask_q))
  ) else $error("count enable set write wrong");

  cnt_clr_write_a: assert property (
    wr_ok && hit(reg_addr, PCER_OFF_CEN_CLR) |=> ((cen_q & wmask_q) == '0)
      && ((cen_q & ~wmask_q) == (cen_prev_q & ~wmask_q))
  ) else $error("count enable clear write wrong");

  reserved_zero_a: assert property (
    ((ien_q | cen_q | flag_q) & ~IMPL_MASK) == '0
  ) else $error("reserved enable bit set");

  user_undef_a: assert property (
    (reg_wr || reg_rd) && user_mode && mapped(reg_addr)
      |=> access_undef && ien_q == ien_prev_q && cen_q == cen_prev_q && reg_rdata == '0
  ) else $error("user mode access not refused");

  irq_global_off_a: assert property (
    !gen_en_q |=> !ovf_irq
  ) else $error("interrupt while globally disabled");

  irq_hold_a: assert property (
    ovf_irq && !wr_ok && !$past(wr_ok) |=> ovf_irq
  ) else $error("interrupt dropped without a write");

  irq_raise_a: assert property (
    gen_en_q && (|(flag_q & ien_q)) |=> ovf_irq
  ) else $error("interrupt not raised");

  run_gate_a: assert property (
    !gen_en_q |=> cnt_run == '0 && !cyc_run
  ) else $error("counter runs while globally disabled");

  cnt_keep_a: assert property (
    !gen_en_q && !(wr_ok && (hit(reg_addr, PCER_OFF_CEN_SET) || hit(reg_addr, PCER_OFF_CEN_CLR)))
      |=> cen_q == cen_prev_q
  ) else $error("count enables changed while disabled");

  flag_clear_a: assert property (
    wr_ok && hit(reg_addr, PCER_OFF_FLAG) |=> (flag_q & wmask_q & ~evt_q) == '0
  ) else $error("overflow flag not cleared");

  shared_read_a: assert property (
    rd_ok && (hit(reg_addr, PCER_OFF_IEN_SET) || hit(reg_addr, PCER_OFF_IEN_CLR))
      |=> reg_rdata == ien_prev_q
  ) else $error("irq enable read mismatch");

  cnt_shared_read_a: assert property (
    rd_ok && (hit(reg_addr, PCER_OFF_CEN_SET) || hit(reg_addr, PCER_OFF_CEN_CLR))
      |=> reg_rdata == cen_prev_q
  ) else $error("count enable read mismatch");

  // a set or clear write must leave the bits written as zero alone
  irq_set_keep_a: assert property (
    wr_ok && hit(reg_addr, PCER_OFF_IEN_SET)
      |=> (ien_q & ~wmask_q) == (ien_prev_q & ~wmask_q)
  ) else $error("irq enable set write touched other bits");

  irq_clr_keep_a: assert property (
    wr_ok && hit(reg_addr, PCER_OFF_IEN_CLR)
      |=> (ien_q & ~wmask_q) == (ien_prev_q & ~wmask_q)
  ) else $error("irq enable clear write touched other bits");

  irq_en_hold_a: assert property (
    !(wr_ok && (hit(reg_addr, PCER_OFF_IEN_SET) || hit(reg_addr, PCER_OFF_IEN_CLR)))
      |=> ien_q == ien_prev_q
  ) else $error("irq enables changed without a write");

  cnt_en_hold_a: assert property (
    !(wr_ok && (hit(reg_addr, PCER_OFF_CEN_SET) || hit(reg_addr, PCER_OFF_CEN_CLR)))
      |=> cen_q == cen_prev_q
  ) else $error("count enables changed without a write");

  ctrl_read_a: assert property (
    rd_ok && hit(reg_addr, PCER_OFF_CTRL)
      |=> reg_rdata[PCER_NCNT_LSB +: PCER_NCNT_W] == NCNT_VAL
  ) else $error("counter count field wrong");

  gen_write_a: assert property (
    wr_ok && hit(reg_addr, PCER_OFF_CTRL) |=> gen_en_q == $past(reg_wdata[PCER_GEN_BIT])
  ) else $error("global enable write lost");

  run_follow_a: assert property (
    gen_en_q |=> cnt_run == cen_prev_q[NUM_CNT-1:0] && cyc_run == cen_prev_q[PCER_CYC_BIT]
  ) else $error("counter run state wrong");

  flag_set_a: assert property (
    |ovf_vec |=> (flag_q & evt_q) == evt_q
  ) else $error("overflow did not set its flag");

  // flags are sticky: only a flag write may drop one
  flag_keep_a: assert property (
    !(wr_ok && hit(reg_addr, PCER_OFF_FLAG)) |=> (flag_q & $past(flag_q)) == $past(flag_q)
  ) else $error("overflow flag lost without a write");

  flag_clr_keep_a: assert property (
    wr_ok && hit(reg_addr, PCER_OFF_FLAG)
      |=> ($past(flag_q) & ~wmask_q & ~flag_q) == '0
  ) else $error("flag clear write touched other bits");

  flag_read_a: assert property (
    rd_ok && hit(reg_addr, PCER_OFF_FLAG) |=> reg_rdata == $past(flag_q)
  ) else $error("overflow flag read mismatch");

  irq_drop_a: assert property (
    !(|(flag_q & ien_q)) |=> !ovf_irq
  ) else $error("interrupt stays with no enabled flag");

  irq_cyc_a: assert property (
    gen_en_q && flag_q[PCER_CYC_BIT] && ien_q[PCER_CYC_BIT] |=> ovf_irq
  ) else $error("cycle counter interrupt missing");

  undef_priv_a: assert property (
    !((reg_wr || reg_rd) && user_mode && mapped(reg_addr)) |=> !access_undef
  ) else $error("undefined flag on a legal access");

  rdata_idle_a: assert property (
    !rd_ok |=> reg_rdata == '0
  ) else $error("read data without a privileged read");

  irq_seen_c: cover property (gen_en_q && ovf_vec[PCER_CYC_BIT] ##[1:3] ovf_irq);
  undef_seen_c: cover property (access_undef);
  irq_cleared_c: cover property (ovf_irq ##1 wr_ok && hit(reg_addr, PCER_OFF_FLAG) ##2 !ovf_irq);
  run_seen_c: cover property (cyc_run && (|cnt_run));
  set_then_clr_c: cover property (
    wr_ok && hit(reg_addr, PCER_OFF_CEN_SET) ##1 wr_ok && hit(reg_addr, PCER_OFF_CEN_CLR));
endmodule
`default_nettype wire

//--- pcer_top_tb_top.sv
/*
  Self-checking bench for the enable bank, driven through its register port.
  Assumes pcer_pkg and the design files are compiled first.
*/
`timescale 1ns/1ps
`default_nettype none
module pcer_top_tb_top;
  import pcer_pkg::*;
  localparam int unsigned NC = 4;
  localparam logic [31:0] IMPL = 32'h8000_0000 | ((32'h1 << NC) - 32'h1);
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  logic [PCER_AW-1:0] reg_addr = '0;
  logic [PCER_DW-1:0] reg_wdata = '0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic user_mode = 1'b0;
  logic [31:0] fire = '0;
  logic [PCER_DW-1:0] reg_rdata;
  logic access_undef;
  logic [NC-1:0] evt_ovf;
  logic cyc_ovf;
  logic [NC-1:0] cnt_run;
  logic cyc_run;
  logic ovf_irq;
  logic [31:0] rdat;
  logic und;
  logic [7:0] base;
  int n_mismatch = 0;
  int checks = 0;
  int cycles = 0;

  always #5 clk = ~clk;

  pcer_top #(.NUM_CNT(NC)) uut (.clk(clk), .arst_n(arst_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .user_mode(user_mode), .access_undef(access_undef), .evt_ovf(evt_ovf),
    .cyc_ovf(cyc_ovf), .cnt_run(cnt_run), .cyc_run(cyc_run), .ovf_irq(ovf_irq));

  pcer_ovf_model #(.NUM_CNT(NC)) src (.clk(clk), .rst_n(arst_n), .fire(fire),
    .evt_ovf(evt_ovf), .cyc_ovf(cyc_ovf));

  task automatic summarize();
    $display("checks %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("Error %s expected %h seen %h", nm, exp, got);
    end
  endtask

  // one strobe cycle; data and undef flag sampled in the cycle after it
  task automatic acc(input logic w, input logic [7:0] a, input logic [31:0] d,
                     input logic um);
    @(posedge clk);
    reg_wr <= w;
    reg_rd <= !w;
    reg_addr <= a;
    reg_wdata <= d;
    user_mode <= um;
    @(posedge clk);
    reg_wr <= 1'b0;
    reg_rd <= 1'b0;
    user_mode <= 1'b0;
    #1;
    rdat = reg_rdata;
    und = access_undef;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    acc(1'b1, a, d, 1'b0);
  endtask

  task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
    acc(1'b0, a, 32'h0, 1'b0);
    chk("reg_rdata", exp, rdat);
  endtask

  task automatic settle(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  // request held one cycle; irq visible two edges after the pulse lands
  task automatic fire_ovf(input logic [31:0] f);
    @(posedge clk);
    fire <= f;
    @(posedge clk);
    fire <= 32'h0;
    settle(2);
  endtask

  always @(posedge clk) begin
    cycles++;
    if (cycles == 3000) begin
      n_mismatch++;
      summarize();
    end
  end

  initial begin
    repeat (2) @(posedge clk);
    arst_n <= 1'b1;
    repeat (3) @(posedge clk);
    // irq enables first, count enables second
    for (int b = 0; b < 2; b++) begin
      base = (b == 0) ? PCER_OFF_IEN_SET : PCER_OFF_CEN_SET;
      wr(base, 32'hffff_ffff);
      rdc(base, IMPL);
      rdc(base + 8'h04, IMPL);
      wr(base, 32'h0);
      wr(base + 8'h04, 32'h0000_0005);
      wr(base + 8'h04, 32'h0);
      rdc(base + 8'h04, 32'h8000_000a);
      rdc(base, 32'h8000_000a);
    end
    rdc(PCER_OFF_CTRL, 32'(NC << PCER_NCNT_LSB));
    chk("run", 32'h0, {27'h0, cyc_run, cnt_run});
    wr(PCER_OFF_CTRL, 32'h1);
    settle(1);
    chk("run", 32'h1a, {27'h0, cyc_run, cnt_run});
    wr(PCER_OFF_CTRL, 32'h0);
    settle(1);
    chk("run", 32'h0, {27'h0, cyc_run, cnt_run});
    rdc(PCER_OFF_CEN_SET, 32'h8000_000a);
    wr(PCER_OFF_CTRL, 32'h1);
    fire_ovf(32'h8000_0000);
    chk("ovf_irq", 32'h1, {31'h0, ovf_irq});
    wr(PCER_OFF_CTRL, 32'h0);
    settle(1);
    chk("ovf_irq", 32'h0, {31'h0, ovf_irq});
    wr(PCER_OFF_CTRL, 32'h1);
    wr(PCER_OFF_FLAG, 32'h0);
    settle(1);
    chk("ovf_irq", 32'h1, {31'h0, ovf_irq});
    wr(PCER_OFF_FLAG, 32'h8000_0000);
    settle(1);
    chk("ovf_irq", 32'h0, {31'h0, ovf_irq});
    fire_ovf(32'h1);
    chk("ovf_irq", 32'h0, {31'h0, ovf_irq});
    rdc(PCER_OFF_FLAG, 32'h1);
    fire_ovf(32'h2);
    chk("ovf_irq", 32'h1, {31'h0, ovf_irq});
    wr(PCER_OFF_FLAG, 32'h2);
    settle(1);
    chk("ovf_irq", 32'h0, {31'h0, ovf_irq});
    // user-mode accesses to mapped registers are refused; an unmapped one is not flagged
    acc(1'b1, PCER_OFF_IEN_CLR, 32'hffff_ffff, 1'b1);
    chk("access_undef", 32'h1, {31'h0, und});
    rdc(PCER_OFF_IEN_SET, 32'h8000_000a);
    acc(1'b0, PCER_OFF_CEN_SET, 32'h0, 1'b1);
    chk("access_undef", 32'h1, {31'h0, und});
    chk("reg_rdata", 32'h0, rdat);
    rdc(8'h3c, 32'h0);
    chk("access_undef", 32'h0, {31'h0, und});
    acc(1'b0, 8'h3c, 32'h0, 1'b1);
    chk("access_undef", 32'h0, {31'h0, und});
    summarize();
  end
endmodule
`default_nettype wire
